/* File: include/apcrc_defines.svh */
// Register offsets, field positions and reset values of the clock control block
`ifndef APCRC_DEFINES_SVH
`define APCRC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define APCRC_OFF_AUX_CTRL     8'h00
`define APCRC_OFF_AUX_FBD      8'h04
`define APCRC_OFF_AUX_OUTDIV   8'h08
`define APCRC_OFF_CAN_CTRL     8'h0C
`define APCRC_OFF_REF_LOW      8'h10
`define APCRC_OFF_REF_HIGH     8'h14
`define APCRC_OFF_REF_TRIM     8'h18

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define APCRC_MASK_AUX_CTRL    16'h810F
`define APCRC_MASK_AUX_FBD     16'h00FF
`define APCRC_MASK_AUX_OUTDIV  16'h0377
`define APCRC_MASK_CAN_CTRL    16'h8F7F
`define APCRC_MASK_REF_LOW     16'hB80F
`define APCRC_MASK_REF_HIGH    16'h7FFF
`define APCRC_MASK_REF_TRIM    16'hFF80
`define APCRC_RST_AUX_CTRL     16'h0001
`define APCRC_RST_AUX_FBD      16'h0096
`define APCRC_RST_AUX_OUTDIV   16'h0041

// ----------------------------------------------------------------------------
// Field positions, prescaler limit and response codes
// ----------------------------------------------------------------------------
`define APCRC_BIT_AUX_EN       15
`define APCRC_BIT_AUX_LOCK     14
`define APCRC_BIT_AUX_SRC_RC   8
`define APCRC_BIT_CAN_EN       15
`define APCRC_BIT_REF_EN       15
`define APCRC_BIT_REF_IDLE     13
`define APCRC_BIT_REF_PIN      12
`define APCRC_BIT_REF_SLEEP    11
`define APCRC_BIT_REF_SWREQ    9
`define APCRC_BIT_REF_ACTIVE   8
`define APCRC_PRE_MAX          4'h8
`define APCRC_RESP_OKAY        2'h0
`define APCRC_RESP_SLVERR      2'h2

`endif

/* File: include/apcrc_pkg.sv */
// Types shared by the clock control block
package apcrc_pkg;

  // --------------------------------------------------------------------------
  // Asynchronous clock sources and status levels entering the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic sleepMode;
    logic idleMode;
    logic auxClockReq;
    logic auxLockIn;
    logic auxVco;
    logic mainPllOut;
    logic mainVco;
    logic periphClock;
    logic sysClock;
    logic refInPin;
    logic backupRc;
    logic lowPowerRc;
    logic fastRc;
    logic primaryOsc;
  } apcrc_src_t;

  typedef enum logic [3:0] {
    CAN_NONE      = 4'h0,
    CAN_MAIN_VCO  = 4'h1,
    CAN_MAIN_PLL  = 4'h2,
    CAN_MAIN_DIV2 = 4'h3,
    CAN_MAIN_DIV3 = 4'h4,
    CAN_MAIN_DIV4 = 4'h5,
    CAN_AUX_PLL   = 4'h6,
    CAN_AUX_VCO   = 4'h7,
    CAN_AUX_DIV2  = 4'h8,
    CAN_AUX_DIV3  = 4'h9,
    CAN_AUX_DIV4  = 4'hA
  } apcrc_can_src_t;

endpackage : apcrc_pkg

/* File: core/apcrc_clock_control.sv */
// Auxiliary PLL, CAN clock generator and reference clock output control
// Overview of operation
// - PLL enable selects post-divider, else bypass
// - PLL starts only with enable and request
// - Lock status bit reflects PLL lock
// - Source bit picks fast RC or primary
// - Prescaler divides by one to eight
// - VCO divider codes select divide four..one
// - CAN generator runs only when enabled
// - CAN source field selects clock tap
// - CAN divider divides by field plus one
// - Reference runs only when enabled
// - Pin enable gates reference onto pin
// - Idle run bit keeps reference in Idle
// - Sleep run bit keeps reference in Sleep
// - Switch request held until divider change done
// - Active status shows reference clock running
// - Reference source field selects base clock
// - Reference divides by twice value, zero passes
// - Trim adds 1/512 fraction per half period
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "apcrc_defines.svh"

// ----------------------------------------------------------------------------
// Edge-counting divider on a synchronous level
// ----------------------------------------------------------------------------
module apcrc_divider #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         src,
  input  wire logic [W-1:0] ratio,
  output logic              divOut
);
  logic         prev;
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic [W:0]   half;

  always_comb begin
    half = ({1'b0, ratio} + {{W{1'b0}}, 1'b1}) >> 1;
    if ({1'b0, count} + {{W{1'b0}}, 1'b1} >= {1'b0, ratio}) begin
      next_count = '0;
    end else begin
      next_count = count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev   <= 1'b0;
      count  <= '0;
      divOut <= 1'b0;
    end else begin
      prev <= src;
      if (ratio <= {{(W-1){1'b0}}, 1'b1}) begin
        count  <= '0;
        divOut <= src;
      end else if (src && !prev) begin
        count  <= next_count;
        divOut <= ({1'b0, next_count} < half);
      end
    end
  end
endmodule : apcrc_divider

// ----------------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------------
module apcrc_clock_control
  import apcrc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire apcrc_src_t  sources,
  output logic [7:0]       auxFeedbackRatio,
  output logic             auxPllRun,
  output logic             auxPllRefClock,
  output logic             auxPllOutClock,
  output logic             canClockOut,
  output logic             refPinOut,
  output logic             refPinOeN,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  apcrc_src_t syncA;
  apcrc_src_t src;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syncA <= '0;
      src   <= '0;
    end else begin
      syncA <= sources;
      src   <= syncA;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [15:0] auxCtrl;
  logic [15:0] auxFbd;
  logic [15:0] auxOutDiv;
  logic [15:0] canCtrl;
  logic [15:0] refLow;
  logic [15:0] refHigh;
  logic [15:0] refTrim;
  logic        auxLocked;
  logic        refRunning;
  logic        switchDone;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (strb[0]) begin
      val[7:0] = data[7:0];
    end
    if (strb[1]) begin
      val[15:8] = data[15:8];
    end
    return (val & mask) | (old & ~mask);
  endfunction : merge

  function automatic logic mapped(input logic [7:0] addr);
    return addr <= `APCRC_OFF_REF_TRIM && addr[1:0] == 2'h0;
  endfunction : mapped

  logic writeTake;
  assign writeTake = awvalid && wvalid && !bvalid && !awready;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      auxCtrl   <= `APCRC_RST_AUX_CTRL;
      auxFbd    <= `APCRC_RST_AUX_FBD;
      auxOutDiv <= `APCRC_RST_AUX_OUTDIV;
      canCtrl   <= 16'h0000;
      refLow    <= 16'h0000;
      refHigh   <= 16'h0000;
      refTrim   <= 16'h0000;
    end else begin
      if (writeTake) begin
        unique case (awaddr)
          `APCRC_OFF_AUX_CTRL:   auxCtrl   <= merge(auxCtrl, wdata, wstrb, `APCRC_MASK_AUX_CTRL);
          `APCRC_OFF_AUX_FBD:    auxFbd    <= merge(auxFbd, wdata, wstrb, `APCRC_MASK_AUX_FBD);
          `APCRC_OFF_AUX_OUTDIV: auxOutDiv <= merge(auxOutDiv, wdata, wstrb, `APCRC_MASK_AUX_OUTDIV);
          `APCRC_OFF_CAN_CTRL:   canCtrl   <= merge(canCtrl, wdata, wstrb, `APCRC_MASK_CAN_CTRL);
          `APCRC_OFF_REF_HIGH:   refHigh   <= merge(refHigh, wdata, wstrb, `APCRC_MASK_REF_HIGH);
          `APCRC_OFF_REF_TRIM:   refTrim   <= merge(refTrim, wdata, wstrb, `APCRC_MASK_REF_TRIM);
          default: ;
        endcase
      end
      // Software write of the switch request wins over the hardware clear
      if (writeTake && awaddr == `APCRC_OFF_REF_LOW) begin
        refLow <= merge(refLow, wdata, wstrb, `APCRC_MASK_REF_LOW);
        if (wstrb[1] && wdata[`APCRC_BIT_REF_SWREQ]) begin
          refLow[`APCRC_BIT_REF_SWREQ] <= 1'b1;
        end else begin
          refLow[`APCRC_BIT_REF_SWREQ] <= refLow[`APCRC_BIT_REF_SWREQ] && !switchDone;
        end
      end else if (switchDone) begin
        refLow[`APCRC_BIT_REF_SWREQ] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `APCRC_RESP_OKAY;
    end else begin
      awready <= writeTake;
      wready  <= writeTake;
      if (writeTake) begin
        bvalid <= 1'b1;
        bresp  <= mapped(awaddr) ? `APCRC_RESP_OKAY : `APCRC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic [15:0] readWord;

  always_comb begin
    readWord = 16'h0000;
    unique case (araddr)
      `APCRC_OFF_AUX_CTRL: begin
        readWord                   = auxCtrl;
        readWord[`APCRC_BIT_AUX_LOCK] = auxLocked;
      end
      `APCRC_OFF_AUX_FBD:    readWord = auxFbd;
      `APCRC_OFF_AUX_OUTDIV: readWord = auxOutDiv;
      `APCRC_OFF_CAN_CTRL:   readWord = canCtrl;
      `APCRC_OFF_REF_LOW: begin
        readWord                       = refLow;
        readWord[`APCRC_BIT_REF_ACTIVE] = refRunning;
      end
      `APCRC_OFF_REF_HIGH:   readWord = refHigh;
      `APCRC_OFF_REF_TRIM:   readWord = refTrim;
      default:               readWord = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `APCRC_RESP_OKAY;
    end else begin
      arready <= arvalid && !rvalid && !arready;
      if (arvalid && !rvalid && !arready) begin
        rvalid <= 1'b1;
        rdata  <= {16'h0000, readWord};
        rresp  <= mapped(araddr) ? `APCRC_RESP_OKAY : `APCRC_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // VCO taps divided by two to four
  // --------------------------------------------------------------------------
  logic [2:0] mainVcoDiv;
  logic [2:0] auxVcoDiv;

  for (genvar k = 0; k < 3; k++) begin : gVcoTap
    apcrc_divider #(.W(3)) uMain (
      .clock  (clock),
      .resetn (resetn),
      .src    (src.mainVco),
      .ratio  (3'(k + 2)),
      .divOut (mainVcoDiv[k])
    );
    apcrc_divider #(.W(3)) uAux (
      .clock  (clock),
      .resetn (resetn),
      .src    (src.auxVco),
      .ratio  (3'(k + 2)),
      .divOut (auxVcoDiv[k])
    );
  end

  // --------------------------------------------------------------------------
  // Auxiliary PLL
  // --------------------------------------------------------------------------
  logic       auxInClock;
  logic [3:0] preRatio;
  logic       preOut;
  logic       vcoTap;
  logic [2:0] post1;
  logic [2:0] post2;
  logic [5:0] postRatio;
  logic       postOut;
  logic       auxEnable;

  always_comb begin
    auxEnable  = auxCtrl[`APCRC_BIT_AUX_EN];
    auxInClock = auxCtrl[`APCRC_BIT_AUX_SRC_RC] ? src.fastRc : src.primaryOsc;
    preRatio   = (auxCtrl[3:0] == 4'h0 || auxCtrl[3:0] > `APCRC_PRE_MAX) ? 4'h1 : auxCtrl[3:0];
    unique case (auxOutDiv[9:8])
      2'h3:    vcoTap = src.auxVco;
      2'h2:    vcoTap = auxVcoDiv[0];
      2'h1:    vcoTap = auxVcoDiv[1];
      default: vcoTap = auxVcoDiv[2];
    endcase
    post1     = (auxOutDiv[6:4] == 3'h0) ? 3'h1 : auxOutDiv[6:4];
    post2     = (auxOutDiv[2:0] == 3'h0) ? 3'h1 : auxOutDiv[2:0];
    postRatio = {3'h0, post1} * {3'h0, post2};
  end

  apcrc_divider #(.W(4)) uPrescale (
    .clock  (clock),
    .resetn (resetn),
    .src    (auxInClock),
    .ratio  (preRatio),
    .divOut (preOut)
  );

  apcrc_divider #(.W(6)) uPost (
    .clock  (clock),
    .resetn (resetn),
    .src    (vcoTap),
    .ratio  (postRatio),
    .divOut (postOut)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      auxPllRun        <= 1'b0;
      auxLocked        <= 1'b0;
      auxPllRefClock   <= 1'b0;
      auxPllOutClock   <= 1'b0;
      auxFeedbackRatio <= 8'h00;
    end else begin
      auxPllRun        <= auxEnable && src.auxClockReq;
      auxLocked        <= auxPllRun && src.auxLockIn;
      auxPllRefClock   <= preOut;
      auxPllOutClock   <= auxEnable ? postOut : auxInClock;
      auxFeedbackRatio <= auxFbd[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // CAN clock generator
  // --------------------------------------------------------------------------
  logic canSel;
  logic canDivOut;

  always_comb begin
    unique case (canCtrl[11:8])
      CAN_MAIN_VCO:  canSel = src.mainVco;
      CAN_MAIN_PLL:  canSel = src.mainPllOut;
      CAN_MAIN_DIV2: canSel = mainVcoDiv[0];
      CAN_MAIN_DIV3: canSel = mainVcoDiv[1];
      CAN_MAIN_DIV4: canSel = mainVcoDiv[2];
      CAN_AUX_PLL:   canSel = auxPllOutClock;
      CAN_AUX_VCO:   canSel = src.auxVco;
      CAN_AUX_DIV2:  canSel = auxVcoDiv[0];
      CAN_AUX_DIV3:  canSel = auxVcoDiv[1];
      CAN_AUX_DIV4:  canSel = auxVcoDiv[2];
      default:       canSel = 1'b0;
    endcase
  end

  apcrc_divider #(.W(8)) uCanDiv (
    .clock  (clock),
    .resetn (resetn),
    .src    (canSel),
    .ratio  ({1'b0, canCtrl[6:0]} + 8'h01),
    .divOut (canDivOut)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      canClockOut <= 1'b0;
    end else begin
      canClockOut <= canCtrl[`APCRC_BIT_CAN_EN] && canDivOut;
    end
  end

  // --------------------------------------------------------------------------
  // Reference clock output
  // --------------------------------------------------------------------------
  logic        refSel;
  logic        refPrev;
  logic        refRun;
  logic        refDivOut;
  logic [15:0] halfCount;
  logic [15:0] halfTarget;
  logic [14:0] activeDiv;
  logic [8:0]  activeTrim;
  logic [8:0]  fracAcc;
  logic        fracExtra;
  logic        halfEnd;
  logic [9:0]  next_frac;

  always_comb begin
    unique case (refLow[3:0])
      4'h0:    refSel = src.sysClock;
      4'h1:    refSel = src.periphClock;
      4'h2:    refSel = src.primaryOsc;
      4'h3:    refSel = src.fastRc;
      4'h4:    refSel = src.lowPowerRc;
      4'h5:    refSel = src.backupRc;
      4'h6:    refSel = mainVcoDiv[2];
      4'h7:    refSel = src.refInPin;
      default: refSel = 1'b0;
    endcase
    refRun = refLow[`APCRC_BIT_REF_EN]
      && !(src.idleMode && !refLow[`APCRC_BIT_REF_IDLE])
      && !(src.sleepMode && !refLow[`APCRC_BIT_REF_SLEEP]);
    halfTarget = {1'b0, activeDiv} + {15'h0000, fracExtra};
    halfEnd    = refSel && !refPrev && activeDiv != 15'h0000
      && (halfCount + 16'h0001 >= halfTarget);
    next_frac  = {1'b0, fracAcc} + {1'b0, activeTrim};
    // Undivided reference switches on a rising source edge, divided one at a half-period end
    switchDone = refLow[`APCRC_BIT_REF_SWREQ] && (halfEnd || !refRunning
      || (activeDiv == 15'h0000 && refSel && !refPrev));
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refPrev    <= 1'b0;
      refDivOut  <= 1'b0;
      halfCount  <= 16'h0000;
      fracAcc    <= 9'h000;
      fracExtra  <= 1'b0;
      activeDiv  <= 15'h0000;
      activeTrim <= 9'h000;
    end else begin
      refPrev <= refSel;
      if (switchDone) begin
        activeDiv  <= refHigh[14:0];
        activeTrim <= refTrim[15:7];
      end
      if (activeDiv == 15'h0000) begin
        refDivOut <= refSel;
        halfCount <= 16'h0000;
      end else if (halfEnd) begin
        refDivOut <= !refDivOut;
        halfCount <= 16'h0000;
        fracAcc   <= next_frac[8:0];
        fracExtra <= next_frac[9];
      end else if (refSel && !refPrev) begin
        halfCount <= halfCount + 16'h0001;
      end
    end
  end

  // Running state drops only once the divided clock has fallen
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      refRunning <= 1'b0;
      refPinOut  <= 1'b0;
      refPinOeN  <= 1'b1;
    end else begin
      refRunning <= refRun || (refRunning && refDivOut);
      refPinOut  <= refRunning && refLow[`APCRC_BIT_REF_PIN] && refDivOut;
      refPinOeN  <= !(refRunning && refLow[`APCRC_BIT_REF_PIN]);
    end
  end

endmodule : apcrc_clock_control

/* File: tb/apcrc_clock_control_checker.sv */
// Port-level timing assertions for the clock control block
`timescale 1ns/1ns
module apcrc_clock_control_checker
  import apcrc_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire apcrc_src_t  sources,
  input wire logic        auxPllRun,
  input wire logic        refPinOut,
  input wire logic        refPinOeN,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready
);
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  run_needs_req_a: assert property ((!sources.auxClockReq) [*4] |=> !auxPllRun)
    else $error("aux PLL running without request");
  pin_gated_a: assert property (refPinOeN && $past(refPinOeN) |-> !refPinOut)
    else $error("reference pin toggles while released");
  wr_answer_a: assert property (awvalid && wvalid && !bvalid && !awready |=> awready && wready && bvalid)
    else $error("write not answered");
  aw_pulse_a: assert property (awready |=> !awready)
    else $error("awready longer than one cycle");
  ready_pair_a: assert property (awready == wready)
    else $error("awready and wready differ");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  b_release_a: assert property (bvalid && bready |=> !bvalid)
    else $error("bvalid held after handshake");
  rd_answer_a: assert property (arvalid && !rvalid && !arready |=> arready && rvalid)
    else $error("read not answered");
  ar_pulse_a: assert property (arready |=> !arready)
    else $error("arready longer than one cycle");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
endmodule : apcrc_clock_control_checker

bind apcrc_clock_control apcrc_clock_control_checker chk (.clock, .resetn, .sources, .auxPllRun, .refPinOut,
  .refPinOeN, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata,
  .rvalid, .rready);

/* File: tb/apcrc_clock_control_tb.sv */
// Self-checking testbench of the clock control block
`timescale 1ns/1ns
module apcrc_clock_control_tb
  import apcrc_pkg::*;
;
  // ------
  // Stimulus, monitors and scenarios
  // ------
  logic        clock = 1'b0, resetn = 1'b0, idle = 1'b0, sleep = 1'b0, req = 1'b0, lockIn = 1'b0;
  apcrc_src_t  sources = '0;
  logic [4:0]  ph = '0;
  logic [7:0]  awaddr = '0, araddr = '0, auxFeedbackRatio;
  logic [31:0] wdata = '0, rdata, rdv;
  logic [3:0]  wstrb = 4'hF, outs;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, prevOut = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        auxPllRun, auxPllRefClock, auxPllOutClock, canClockOut, refPinOut, refPinOeN;
  logic [1:0]  bresp, rresp, lastResp;
  int          mismatches = 0, comparisons = 0, rises = 0, cyc = 0, sel = 0;

  apcrc_clock_control dut (.clock, .resetn, .sources, .auxFeedbackRatio, .auxPllRun, .auxPllRefClock,
    .auxPllOutClock, .canClockOut, .refPinOut, .refPinOeN, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  initial forever #50 clock = ~clock;
  assign outs = {refPinOut, canClockOut, auxPllOutClock, auxPllRefClock};

  // Source clocks as divided levels of one counter
  always @(posedge clock) begin
    ph <= ph + 5'h01;
    sources <= '{sleepMode: sleep, idleMode: idle, auxClockReq: req, auxLockIn: lockIn, auxVco: ph[0],
      mainPllOut: ph[1], mainVco: ph[0], periphClock: ph[3], sysClock: ph[2], refInPin: ph[1],
      backupRc: ph[3], lowPowerRc: ph[4], fastRc: ph[1], primaryOsc: ph[0]};
  end

  always @(posedge clock) begin
    if (outs[sel] === 1'b1 && prevOut === 1'b0)
      rises = rises + 1;
    prevOut = outs[sel];
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clock); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clock);
    lastResp = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    rdv = rdata;
    lastResp = rresp;
    rready <= 1'b0;
  endtask : rd

  task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    check(n, rdv, e);
  endtask : rdchk

  // Counts rising edges of one output over a window, one edge of slack
  task meas(input string n, input int s, input int w, input int e);
    repeat (40) @(posedge clock);
    sel = s;
    rises = 0;
    repeat (w) @(posedge clock);
    check(n, 32'(rises >= e - 1 && rises <= e + 1), 32'h1);
  endtask : meas

  task wm(input string n, input logic [7:0] a, input logic [31:0] d, input int s, input int e);
    wr(a, d);
    meas(n, s, 480, e);
  endtask : wm

  task waitbit(input logic [7:0] a, input int b);
    int i;
    for (i = 0; i < 100; i++) begin
      rd(a);
      if (rdv[b] === 1'b0)
        break;
    end
  endtask : waitbit

  // Stops the reference, waits for it to go idle, then applies a new setting
  task refsel(input logic [31:0] v);
    wr(8'h10, 32'h0);
    waitbit(8'h10, 8);
    check("ref active after stop", 32'(rdv[8]), 32'h0);
    wr(8'h10, v);
  endtask : refsel

  task test_regs;
    rdchk("aux ctrl reset", 8'h00, 32'h1);
    rdchk("fbd reset", 8'h04, 32'h96);
    rdchk("outdiv reset", 8'h08, 32'h41);
    rdchk("can reset", 8'h0C, 32'h0);
    rdchk("ref reset", 8'h10, 32'h0);
    check("ratio port reset", 32'(auxFeedbackRatio), 32'h96);
    wr(8'h08, 32'hFFFF);
    rdchk("outdiv fields", 8'h08, 32'h377);
    wr(8'h0C, 32'hFFFF);
    rdchk("can fields", 8'h0C, 32'h8F7F);
    wr(8'h00, 32'hFFFF);
    rdchk("aux fields", 8'h00, 32'h810F);
    wr(8'h00, 32'h1);
    wr(8'h1C, 32'h1);
    check("unmapped write", 32'(lastResp), 32'h2);
    rdchk("unmapped data", 8'h1C, 32'h0);
    check("unmapped read", 32'(lastResp), 32'h2);
    wr(8'h02, 32'h1);
    check("misaligned write", 32'(lastResp), 32'h2);
    wr(8'h04, 32'h00C8);
    rdchk("fbd write", 8'h04, 32'hC8);
    check("ratio port", 32'(auxFeedbackRatio), 32'hC8);
    $display("test_regs done");
  endtask : test_regs

  task test_aux;
    int p;
    for (p = 0; p < 10; p++)
      wm("prescale", 8'h00, 32'(p), 0, 240 / ((p < 1 || p > 8) ? 1 : p));
    wm("fast rc input", 8'h00, 32'h0102, 0, 60);
    wm("bypass", 8'h00, 32'h0101, 1, 120);
    wr(8'h08, 32'h0311);
    wm("vco undivided", 8'h00, 32'h8101, 1, 240);
    wm("vco half", 8'h08, 32'h0211, 1, 120);
    wm("vco third", 8'h08, 32'h0111, 1, 80);
    wm("post div", 8'h08, 32'h0041, 1, 15);
    lockIn <= 1'b1;
    repeat (8) @(posedge clock);
    check("run without request", 32'(auxPllRun), 32'h0);
    rdchk("lock without run", 8'h00, 32'h8101);
    req <= 1'b1;
    repeat (8) @(posedge clock);
    check("run with request", 32'(auxPllRun), 32'h1);
    rdchk("lock set", 8'h00, 32'hC101);
    lockIn <= 1'b0;
    req <= 1'b0;
    repeat (8) @(posedge clock);
    rdchk("lock lost", 8'h00, 32'h8101);
    $display("test_aux done");
  endtask : test_aux

  task test_can;
    int c;
    static int rate [16] = '{0, 240, 120, 120, 80, 60, 120, 240, 120, 80, 60, 0, 0, 0, 0, 0};
    wr(8'h00, 32'h0101);
    for (c = 0; c < 16; c++)
      wm("can source", 8'h0C, 32'h8000 | (c << 8), 2, rate[c]);
    for (c = 0; c < 3; c++) begin
      wr(8'h0C, 32'h0100 | c);
      wm("can divide", 8'h0C, 32'h8100 | c, 2, 240 / (c + 1));
    end
    wr(8'h0C, 32'h017F);
    wr(8'h0C, 32'h817F);
    meas("can divide 128", 2, 2048, 8);
    wm("can disabled", 8'h0C, 32'h0101, 2, 0);
    check("can idle level", 32'(canClockOut), 32'h0);
    $display("test_can done");
  endtask : test_can

  task test_ref;
    int s;
    static int rate [9] = '{60, 30, 240, 120, 15, 30, 60, 120, 0};
    for (s = 0; s < 9; s++) begin
      refsel(32'h9000 | s);
      meas("ref source", 3, 480, rate[s]);
    end
    refsel(32'h9002);
    rdchk("ref running", 8'h10, 32'h9102);
    check("pin driven", 32'(refPinOeN), 32'h0);
    refsel(32'h8002);
    meas("pin gated", 3, 480, 0);
    check("pin released", 32'(refPinOeN), 32'h1);
    idle <= 1'b1;
    refsel(32'h9002);
    meas("idle stop", 3, 480, 0);
    refsel(32'hB002);
    meas("idle run", 3, 480, 240);
    idle <= 1'b0;
    sleep <= 1'b1;
    refsel(32'h9002);
    meas("sleep stop", 3, 480, 0);
    refsel(32'h9802);
    meas("sleep run", 3, 480, 240);
    sleep <= 1'b0;
    refsel(32'h9002);
    wr(8'h14, 32'h2);
    meas("held before switch", 3, 480, 240);
    wr(8'h10, 32'h9202);
    waitbit(8'h10, 9);
    check("switch done", rdv, 32'h9102);
    meas("ref divide 4", 3, 480, 60);
    wr(8'h18, 32'h8000);
    wr(8'h14, 32'h1);
    wr(8'h10, 32'h9202);
    waitbit(8'h10, 9);
    meas("ref trim half", 3, 480, 80);
    $display("test_ref done");
  endtask : test_ref

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    test_regs();
    test_aux();
    test_can();
    test_ref();
    report_and_stop();
  end
endmodule : apcrc_clock_control_tb
